// ==== core/spfcl_core.sv ====
// Single-phase fan commutation, speed PWM and lock supervision core
//
// Function
// [R1] Hall positive above negative selects phase B, else phase A.
// [R2] Demand 3V gives 0% low-side duty, 1V gives 100%.
// [R3] Demand above 3V turns PWM off unless minimum clamp active.
// [R4] Demand at ground gives continuous full drive.
// [R5] In PWM mode input duty integrates to a 3V..1V demand level.
// [R6] Host should drive the speed PWM input near 25 kHz.
// [R7] Effective demand never asks slower than the minimum setting.
// [R8] Minimum setting at reference level disables the clamp.
// [R9] While running, lock timing restarts at each Hall change.
// [R10] After soft-start, no Hall change within detect time disables drive.
// [R11] After lock, stay undriven for off time, then soft-start.
// [R12] No Hall change by soft-start end returns to locked off.
// [R13] Hall activity by soft-start end enters lock detection.
// [R14] Soft-start ramps threshold source from zero to nominal 4.9V.
// [R15] Sense above threshold reduces output PWM duty.
// [R16] Tacho copies Hall state, driven low only.
// [R17] Low-side outputs carry commutation and PWM on active phase.
// [R18] High-side outputs carry commutation only, as sinking outputs.
// [R19] Inactive low-side output held low by weak pull-down.
// [R20] Lock detect time to off time ratio is one to eight.
// [R21] Soft-start, detect and off times come from counters.
// [R22] Duty varies linearly with demand between end points.
`default_nettype none
module spfcl_core
    import spfcl_pkg::*;
#(
    parameter int unsigned SOFT_START_CYCLES  = 32'(SOFT_START_CYC),
    parameter int unsigned LOCK_DETECT_CYCLES = 32'(LOCK_DETECT_CYC),
    parameter int unsigned INTEG_SHIFT        = 4
) (
    input  wire logic       CLOCK,
    input  wire logic       RST_N,
    input  wire logic       CLK_EN,
    input  wire logic [7:0] HALL_POS,
    input  wire logic [7:0] HALL_NEG,
    input  wire logic       PWM_MODE,
    input  wire logic [7:0] SPEED_DEMAND_LEVEL,
    input  wire logic       SPEED_PWM_IN,
    input  wire logic [7:0] MINIMUM_SPEED_SETTING,
    input  wire logic [7:0] CURRENT_SENSE,
    input  wire logic [7:0] CURRENT_THRESHOLD,
    output logic            PHASE_A_LOW_DRIVE,
    output logic            PHASE_B_LOW_DRIVE,
    output logic            PHASE_A_LOW_PULLDOWN,
    output logic            PHASE_B_LOW_PULLDOWN,
    output logic            PHASE_A_HIGH_DRIVE_O,
    output logic            PHASE_A_HIGH_DRIVE_OE,
    output logic            PHASE_B_HIGH_DRIVE_O,
    output logic            PHASE_B_HIGH_DRIVE_OE,
    output logic            TACHO_OUT_O,
    output logic            TACHO_OUT_OE,
    output logic [7:0]      CURRENT_THRESHOLD_SOURCE,
    output logic [7:0]      SPEED_PWM_INTEGRATOR,
    output logic            LOCKED
);
    // ------------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------------
    localparam int unsigned OFF_CYCLES =
        32'(longint'(OFF_RATIO) * LOCK_DETECT_CYCLES);        // [R20]
    localparam int unsigned RAMP_STEP =
        (SOFT_START_CYCLES / 245 > 0) ? SOFT_START_CYCLES / 245 : 1;

    // ------------------------------------------------------------------
    // Demand to duty, linear between 3V and 1V
    // ------------------------------------------------------------------
    function automatic logic [6:0] level_to_duty(input logic [7:0] lv);
        logic [7:0] d;
        d = LV_3V - lv;
        if (lv >= LV_3V)
            level_to_duty = 7'h00;                              // [R3]
        else if (lv <= LV_1V)
            level_to_duty = DUTY_FULL;                          // [R4]
        else
            level_to_duty = d[6:0];                             // [R22]
    endfunction

    spfcl_state_t state;
    spfcl_drive_t next_drive;
    logic [31:0]  timer;
    logic         hall_q;
    logic         hall_primed;
    logic         seen_change;
    logic [7:0]   src;
    logic [31:0]  ramp_pre;
    logic [15:0]  integ;
    logic [6:0]   pwm_cnt;
    logic [6:0]   cut;
    logic         hall_b;
    logic         hall_chg;
    logic [7:0]   raw_lv;
    logic [7:0]   eff_lv;
    logic         clamp_on;
    logic [6:0]   duty;
    logic [6:0]   duty_eff;
    logic [15:0]  thr_prod;
    logic [7:0]   thr_eff;
    logic         pwm_on;
    logic         running;

    // ------------------------------------------------------------------
    // Commutation and demand path
    // ------------------------------------------------------------------
    assign hall_b   = HALL_POS > HALL_NEG;                      // [R1]
    assign hall_chg = hall_primed && (hall_b != hall_q);
    assign raw_lv   = PWM_MODE ? integ[15:8] : SPEED_DEMAND_LEVEL;
    assign clamp_on = (MINIMUM_SPEED_SETTING != LV_REF)         // [R8]
                      && (raw_lv > MINIMUM_SPEED_SETTING);
    assign eff_lv   = clamp_on ? MINIMUM_SPEED_SETTING : raw_lv; // [R7]
    assign duty     = level_to_duty(eff_lv);                    // [R2]
    assign duty_eff = (duty > cut) ? duty - cut : 7'h00;        // [R15]
    assign thr_prod = 16'(CURRENT_THRESHOLD) * 16'(src);
    assign thr_eff  = 8'(thr_prod / 16'(LV_SRC_NOM));
    assign pwm_on   = pwm_cnt < duty_eff;
    assign running  = state != ST_OFF;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hall_q      <= 1'b0;
            hall_primed <= 1'b0;
        end else if (CLK_EN) begin
            hall_q      <= hall_b;
            hall_primed <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Speed PWM integrator, first-order toward 1V or 3V
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            integ <= INTEG_RST;
        end else if (CLK_EN) begin
            if (SPEED_PWM_IN)
                integ <= integ - ((integ - {LV_1V, 8'h00}) >> INTEG_SHIFT);
            else
                integ <= integ + (({LV_3V, 8'h00} - integ) >> INTEG_SHIFT);
        end                                                      // [R5]
    end

    // ------------------------------------------------------------------
    // PWM carrier and current back-off
    // ------------------------------------------------------------------
    // Back-off moves one step per period so a single noisy sample of
    // sense cannot collapse the drive.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pwm_cnt <= 7'h00;
            cut     <= 7'h00;
        end else if (CLK_EN) begin
            if (pwm_cnt == DUTY_FULL - 7'h01) begin
                pwm_cnt <= 7'h00;
                if (CURRENT_SENSE > thr_eff && cut < DUTY_FULL)
                    cut <= cut + 7'h01;                         // [R15]
                else if (CURRENT_SENSE <= thr_eff && cut != 7'h00)
                    cut <= cut - 7'h01;
            end else begin
                pwm_cnt <= pwm_cnt + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Lock supervision state machine
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state       <= ST_SOFT;
            timer       <= 32'h0000_0000;
            seen_change <= 1'b0;
        end else if (CLK_EN) begin
            case (state)
                ST_SOFT: begin
                    if (hall_chg)
                        seen_change <= 1'b1;
                    if (timer == SOFT_START_CYCLES - 1) begin   // [R21]
                        timer <= 32'h0000_0000;
                        if (seen_change || hall_chg)
                            state <= ST_RUN;                    // [R13]
                        else
                            state <= ST_OFF;                    // [R12]
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                ST_RUN: begin
                    if (hall_chg) begin
                        timer <= 32'h0000_0000;                 // [R9]
                    end else if (timer == LOCK_DETECT_CYCLES - 1) begin
                        timer <= 32'h0000_0000;
                        state <= ST_OFF;                        // [R10]
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
                default: begin
                    if (timer == OFF_CYCLES - 1) begin          // [R11]
                        timer       <= 32'h0000_0000;
                        seen_change <= 1'b0;
                        state       <= ST_SOFT;
                    end else begin
                        timer <= timer + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Threshold source ramp
    // ------------------------------------------------------------------
    // The source is held at zero while locked so every restart ramps
    // the current limit up from nothing.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            src      <= 8'h00;
            ramp_pre <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (state == ST_OFF) begin
                src      <= 8'h00;
                ramp_pre <= 32'h0000_0000;
            end else if (state == ST_RUN) begin
                src <= LV_SRC_NOM;
            end else if (ramp_pre == RAMP_STEP - 1) begin
                ramp_pre <= 32'h0000_0000;
                if (src < LV_SRC_NOM)
                    src <= src + 8'h01;                         // [R14]
            end else begin
                ramp_pre <= ramp_pre + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    always_comb begin
        next_drive.a_low  = running && !hall_b && pwm_on;       // [R17]
        next_drive.b_low  = running && hall_b && pwm_on;
        next_drive.a_high = running && !hall_b;                 // [R18]
        next_drive.b_high = running && hall_b;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PHASE_A_LOW_DRIVE     <= 1'b0;
            PHASE_B_LOW_DRIVE     <= 1'b0;
            PHASE_A_LOW_PULLDOWN  <= 1'b1;
            PHASE_B_LOW_PULLDOWN  <= 1'b1;
            PHASE_A_HIGH_DRIVE_O  <= 1'b0;
            PHASE_A_HIGH_DRIVE_OE <= 1'b0;
            PHASE_B_HIGH_DRIVE_O  <= 1'b0;
            PHASE_B_HIGH_DRIVE_OE <= 1'b0;
        end else if (CLK_EN) begin
            PHASE_A_LOW_DRIVE     <= next_drive.a_low;
            PHASE_B_LOW_DRIVE     <= next_drive.b_low;
            PHASE_A_LOW_PULLDOWN  <= !(running && !hall_b);     // [R19]
            PHASE_B_LOW_PULLDOWN  <= !(running && hall_b);
            PHASE_A_HIGH_DRIVE_O  <= 1'b0;
            PHASE_A_HIGH_DRIVE_OE <= next_drive.a_high;         // [R18]
            PHASE_B_HIGH_DRIVE_O  <= 1'b0;
            PHASE_B_HIGH_DRIVE_OE <= next_drive.b_high;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            TACHO_OUT_O              <= 1'b0;
            TACHO_OUT_OE             <= 1'b0;
            CURRENT_THRESHOLD_SOURCE <= 8'h00;
            SPEED_PWM_INTEGRATOR     <= LV_3V;
            LOCKED                   <= 1'b0;
        end else if (CLK_EN) begin
            TACHO_OUT_O              <= 1'b0;
            TACHO_OUT_OE             <= !hall_b;                // [R16]
            CURRENT_THRESHOLD_SOURCE <= src;
            SPEED_PWM_INTEGRATOR     <= integ[15:8];
            LOCKED                   <= state == ST_OFF;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_phase_exclusive: assert property ( // [R1]
        @(posedge CLOCK) disable iff (!RST_N)
        !(PHASE_A_HIGH_DRIVE_OE && PHASE_B_HIGH_DRIVE_OE))
        else $error("both high-side outputs active");
    a_locked_quiet: assert property ( // [R10]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_OFF) |=> !PHASE_A_LOW_DRIVE
            && !PHASE_B_LOW_DRIVE && !PHASE_A_HIGH_DRIVE_OE
            && !PHASE_B_HIGH_DRIVE_OE)
        else $error("drive active while locked");
    a_lock_enter: assert property ( // [R10]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_RUN && !hall_chg
            && timer == LOCK_DETECT_CYCLES - 1) |=> state == ST_OFF)
        else $error("lock not detected at timeout");
    a_hall_restart: assert property ( // [R9]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_RUN && hall_chg) |=>
            (state == ST_RUN && timer == 32'h0000_0000))
        else $error("lock timer not restarted on hall change");
    a_off_hold: assert property ( // [R11]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_OFF && timer != OFF_CYCLES - 1)
            |=> state == ST_OFF)
        else $error("left off period early");
    a_off_length: assert property ( // [R20]
        @(posedge CLOCK) disable iff (!RST_N)
        (state == ST_OFF) |-> timer < OFF_CYCLES)
        else $error("off timer beyond eight detect periods");
    a_soft_fail: assert property ( // [R12]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_SOFT && timer == SOFT_START_CYCLES - 1
            && !seen_change && !hall_chg) |=> state == ST_OFF)
        else $error("restart without hall activity not relocked");
    a_soft_pass: assert property ( // [R13]
        @(posedge CLOCK) disable iff (!RST_N)
        (CLK_EN && state == ST_SOFT && timer == SOFT_START_CYCLES - 1
            && seen_change) |=> state == ST_RUN)
        else $error("running motor not moved to lock detection");
    a_full_duty: assert property ( // [R4]
        @(posedge CLOCK) disable iff (!RST_N)
        (eff_lv <= LV_1V) |-> duty == DUTY_FULL)
        else $error("full demand without full duty");
    a_disable_duty: assert property ( // [R3]
        @(posedge CLOCK) disable iff (!RST_N)
        (eff_lv >= LV_3V) |-> duty == 7'h00)
        else $error("disable demand still gives duty");
    a_tacho_follow: assert property ( // [R16]
        @(posedge CLOCK) disable iff (!RST_N)
        CLK_EN |=> TACHO_OUT_OE == !$past(hall_b) && !TACHO_OUT_O)
        else $error("tacho does not follow hall");
endmodule // spfcl_core
`default_nettype wire

// ==== core/spfcl_pkg.sv ====
// Constants and types shared by the fan commutation and lock core
`default_nettype none
package spfcl_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned     CLOCK_MHZ      = 250;
    localparam int unsigned     SOFT_START_MS  = 3000;
    localparam int unsigned     LOCK_DETECT_MS = 400;
    localparam int unsigned     OFF_RATIO      = 8;
    localparam longint unsigned SOFT_START_CYC =
        longint'(SOFT_START_MS) * 1000 * CLOCK_MHZ;
    localparam longint unsigned LOCK_DETECT_CYC =
        longint'(LOCK_DETECT_MS) * 1000 * CLOCK_MHZ;

    // ------------------------------------------------------------------
    // Level codes, 20 mV per step
    // ------------------------------------------------------------------
    localparam int          LV_W       = 8;
    localparam logic [7:0]  LV_1V      = 8'h32;
    localparam logic [7:0]  LV_3V      = 8'h96;
    localparam logic [7:0]  LV_REF     = 8'hFA;
    localparam logic [7:0]  LV_SRC_NOM = 8'hF5;
    localparam logic [6:0]  DUTY_FULL  = 7'h64;
    localparam logic [15:0] INTEG_RST  = 16'h9600;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SOFT,
        ST_RUN,
        ST_OFF
    } spfcl_state_t;

    typedef struct packed {
        logic a_low;
        logic b_low;
        logic a_high;
        logic b_high;
    } spfcl_drive_t;
endpackage
`default_nettype wire

// ==== test/spfcl_partner.sv ====
// Behavioural rotor, Hall sensor and H-bridge current seen by the core
`default_nettype none
module spfcl_partner
    import spfcl_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         spin,
    input  wire logic [15:0]  half_per,
    input  wire logic [7:0]   sense_amp,
    input  wire spfcl_drive_t bridge,
    output logic [7:0]        hall_pos,
    output logic [7:0]        hall_neg,
    output logic [7:0]        sense
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        hall;
    logic        wrap;
    logic        energised;
    logic [15:0] cnt;

    // The rotor only turns while a high side is sunk and it is not stalled
    assign energised = bridge.a_high | bridge.b_high;
    assign wrap      = cnt >= half_per - 16'h0001;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 16'h0000;
            hall <= 1'b0;
        end else if (spin && energised) begin
            cnt  <= wrap ? 16'h0000 : cnt + 16'h0001;
            hall <= wrap ? ~hall : hall;
        end
    end

    // Buffered sensor: negative input held at mid level by a divider
    assign hall_pos = hall ? 8'hC0 : 8'h40;
    assign hall_neg = 8'h80;
    // Coil current decays slowly, so it reads steady while energised
    assign sense    = energised ? sense_amp : 8'h00;
endmodule // spfcl_partner
`default_nettype wire

// ==== test/test_single_phase_fan_commutation_lock.sv ====
// Self-checking bench for the fan commutation and lock core
`default_nettype none
module test_single_phase_fan_commutation_lock
    import spfcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SS = 2000;
    localparam int LD = 200;
    localparam int PWM_HALF = CLOCK_MHZ * 1000 / 25 / 2;

    logic CLOCK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, spin = 1'b1;
    logic PWM_MODE = 1'b0, SPEED_PWM_IN = 1'b0;
    logic [7:0] SPEED_DEMAND_LEVEL = 8'h00, MINIMUM_SPEED_SETTING = 8'hFA;
    logic [7:0] CURRENT_THRESHOLD = 8'h64, sense_amp = 8'h00;
    logic [15:0] half_per = 16'h0096;
    logic [7:0] HALL_POS, HALL_NEG, CURRENT_SENSE;
    logic [7:0] CURRENT_THRESHOLD_SOURCE, SPEED_PWM_INTEGRATOR;
    logic PHASE_A_LOW_DRIVE, PHASE_B_LOW_DRIVE, PHASE_A_LOW_PULLDOWN;
    logic PHASE_B_LOW_PULLDOWN, PHASE_A_HIGH_DRIVE_O, PHASE_A_HIGH_DRIVE_OE;
    logic PHASE_B_HIGH_DRIVE_O, PHASE_B_HIGH_DRIVE_OE, TACHO_OUT_O;
    logic TACHO_OUT_OE, LOCKED, hall_q = 1'b0;
    spfcl_drive_t bridge;
    int errors = 0, checked = 0, since = 0, st_l = 0;

    always #2 CLOCK = ~CLOCK;

    spfcl_core #(.SOFT_START_CYCLES(SS), .LOCK_DETECT_CYCLES(LD),
                 .INTEG_SHIFT(4)) dut (
        .CLOCK, .RST_N, .CLK_EN, .HALL_POS, .HALL_NEG, .PWM_MODE,
        .SPEED_DEMAND_LEVEL, .SPEED_PWM_IN, .MINIMUM_SPEED_SETTING,
        .CURRENT_SENSE, .CURRENT_THRESHOLD, .PHASE_A_LOW_DRIVE,
        .PHASE_B_LOW_DRIVE, .PHASE_A_LOW_PULLDOWN, .PHASE_B_LOW_PULLDOWN,
        .PHASE_A_HIGH_DRIVE_O, .PHASE_A_HIGH_DRIVE_OE, .PHASE_B_HIGH_DRIVE_O,
        .PHASE_B_HIGH_DRIVE_OE, .TACHO_OUT_O, .TACHO_OUT_OE,
        .CURRENT_THRESHOLD_SOURCE, .SPEED_PWM_INTEGRATOR, .LOCKED);

    assign bridge = {PHASE_A_LOW_DRIVE, PHASE_B_LOW_DRIVE,
                     PHASE_A_HIGH_DRIVE_OE, PHASE_B_HIGH_DRIVE_OE};

    spfcl_partner fan (.clock(CLOCK), .rst_n(RST_N), .spin, .half_per,
        .sense_amp, .bridge, .hall_pos(HALL_POS), .hall_neg(HALL_NEG),
        .sense(CURRENT_SENSE));

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Passes a value inside the window, otherwise expects the low end
    function automatic logic [15:0] near(logic [15:0] g, int lo, int hi);
        return ((g >= lo && g <= hi) === 1'b1) ? g : 16'(lo);
    endfunction

    function automatic int exp_duty(int lv, int mn);
        if (mn != 250 && lv > mn) lv = mn;
        return lv >= 150 ? 0 : lv <= 50 ? 100 : 150 - lv;
    endfunction

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask

    task automatic duty(output int d);
        logic on;
        d = 0;
        repeat (100) begin
            tick(1);
            // An unknown drive level inflates the count so it cannot pass
            on = PHASE_A_LOW_DRIVE | PHASE_B_LOW_DRIVE;
            d += (on === 1'b1) ? 1 : (on === 1'b0) ? 0 : 200;
        end
    endtask

    task automatic wait_lock(input logic v, input int bound, output int n);
        for (n = 0; n < bound && LOCKED !== v; n++)
            tick(1);
        if (n == bound) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, LOCKED, v);
            wrap_up;
        end
    endtask

    task automatic run_duty(input int lv, input int mn);
        int d;
        SPEED_DEMAND_LEVEL = 8'(lv);
        MINIMUM_SPEED_SETTING = 8'(mn);
        tick(250);
        duty(d);
        chk(16'(d), 16'(exp_duty(lv, mn)));
    endtask

    // ------------------------------------------------------------------
    // Pin monitor, sampled on the falling edge away from any update
    // ------------------------------------------------------------------
    always @(negedge CLOCK) begin : monitor
        logic h;
        h = HALL_POS > HALL_NEG;
        since = (!RST_N || !CLK_EN || h != hall_q) ? 0 : since + 1;
        st_l = (LOCKED === 1'b0 && since > 0) ? st_l + 1 : 0;
        hall_q = h;
        if (since >= 3) begin
            chk({TACHO_OUT_O, TACHO_OUT_OE}, {1'b0, !h});
        end
        if (st_l >= 3) begin
            chk({PHASE_B_HIGH_DRIVE_OE, PHASE_A_HIGH_DRIVE_OE}, {h, !h});
            chk({PHASE_A_HIGH_DRIVE_O, PHASE_B_HIGH_DRIVE_O}, 2'b00);
            chk({PHASE_A_LOW_PULLDOWN, PHASE_B_LOW_PULLDOWN}, {h, !h});
            chk(h ? PHASE_A_LOW_DRIVE : PHASE_B_LOW_DRIVE, 1'b0);
        end
        if (RST_N && LOCKED === 1'b1)
            chk(bridge, 4'h0);
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : main
        int q[$];
        int d, n;
        logic [15:0] snap;
        q = '{16'h00FA, 16'h32FA, 16'h96FA, 16'h97FA, 16'h95FA,
              16'hC8FA, 16'hC882, 16'h64FA, 16'h6450};
        void'($urandom(97));
        tick(10);
        RST_N = 1'b1;
        tick(4);
        chk(CURRENT_THRESHOLD_SOURCE,
            near(CURRENT_THRESHOLD_SOURCE, 0, 2));
        tick(996);
        chk(CURRENT_THRESHOLD_SOURCE,
            near(CURRENT_THRESHOLD_SOURCE, 110, 140));
        tick(1100);
        chk(LOCKED, 1'b0);
        chk(CURRENT_THRESHOLD_SOURCE, LV_SRC_NOM);
        $display("test soft start done");

        for (int i = 0; i < 8; i++)
            q.push_back(int'($urandom_range(149, 51)) * 256 +
                ($urandom_range(1, 0) ? 250 : int'($urandom_range(140, 60))));
        half_per = 16'($urandom_range(190, 100));
        foreach (q[i])
            run_duty(q[i] / 256, q[i] % 256);
        MINIMUM_SPEED_SETTING = 8'hFA;
        $display("test demand level done");

        PWM_MODE = 1'b1;
        SPEED_PWM_IN = 1'b1;
        tick(400);
        chk(SPEED_PWM_INTEGRATOR, LV_1V);
        duty(d);
        chk(16'(d), 16'h0064);
        SPEED_PWM_IN = 1'b0;
        MINIMUM_SPEED_SETTING = 8'h64;
        tick(400);
        chk(SPEED_PWM_INTEGRATOR, near(SPEED_PWM_INTEGRATOR, 149, 150));
        duty(d);
        chk(16'(d), 16'(exp_duty(150, 100)));
        MINIMUM_SPEED_SETTING = 8'hFA;
        // Host speed signal at the recommended 25 kHz
        repeat (2) begin
            SPEED_PWM_IN = 1'b1;
            tick(PWM_HALF);
            chk(SPEED_PWM_INTEGRATOR, LV_1V);
            SPEED_PWM_IN = 1'b0;
            tick(PWM_HALF);
            chk(SPEED_PWM_INTEGRATOR,
                near(SPEED_PWM_INTEGRATOR, 149, 150));
        end
        PWM_MODE = 1'b0;
        $display("test speed pwm done");

        SPEED_DEMAND_LEVEL = 8'h00;
        sense_amp = 8'hFF;
        tick(2000);
        duty(d);
        chk(16'(d), near(16'(d), 76, 82));
        sense_amp = 8'h00;
        tick(3000);
        duty(d);
        chk(16'(d), 16'h0064);
        $display("test current limit done");

        CLK_EN = 1'b0;
        snap = {bridge, TACHO_OUT_OE, LOCKED, CURRENT_THRESHOLD_SOURCE};
        tick(20);
        chk({bridge, TACHO_OUT_OE, LOCKED, CURRENT_THRESHOLD_SOURCE}, snap);
        CLK_EN = 1'b1;
        half_per = 16'h00BE;
        tick(1500);
        chk(LOCKED, 1'b0);
        $display("test hold and retrigger done");

        spin = 1'b0;
        wait_lock(1'b1, 400, n);
        chk(16'(since), near(16'(since), LD, LD + 6));
        wait_lock(1'b0, 1700, n);
        chk(16'(n), near(16'(n), 8 * LD - 2, 8 * LD + 2));
        wait_lock(1'b1, 2100, n);
        chk(16'(n), near(16'(n), SS - 2, SS + 4));
        spin = 1'b1;
        wait_lock(1'b0, 1700, n);
        tick(SS + 20);
        chk(LOCKED, 1'b0);
        chk(CURRENT_THRESHOLD_SOURCE, LV_SRC_NOM);
        $display("test lock and restart done");
        wrap_up;
    end
endmodule // test_single_phase_fan_commutation_lock
`default_nettype wire
